// ==== ebhh_top.sv ====
// external memory port with bus hold handoff to an outside master
// assumes one system clock equal to the cpu clock; user side on that clock
`timescale 1ns/1ps
module ebhh_top
  import ebhh_pkg::*;
(
  // clock and reset
  input  wire logic                   I_CLK_SYS,
  input  wire logic                   I_SYS_RST,
  // access request
  input  wire logic                   I_ACC_VALID,
  output logic                        O_ACC_READY,
  input  wire ebhh_kind_type          I_ACC_KIND,
  input  wire logic [1:0]             I_ACC_SPACE,
  input  wire logic [ADDR_HI:ADDR_LO] I_ACC_ADDR,
  input  wire logic [BE_W-1:0]        I_ACC_BE,
  input  wire logic [DATA_W-1:0]      I_ACC_WDATA,
  // access answer
  output logic                        O_ACC_DONE,
  output logic                        O_RD_VALID,
  output logic [DATA_W-1:0]           O_RD_DATA,
  // control
  input  wire logic                   I_GRANT_REFUSE_BIT,
  input  wire logic                   I_BURST_LIMIT_SETTING,
  // hold handshake
  input  wire logic                   I_HOLD_REQ_N,
  output logic                        O_BUS_GRANT_ACK_N,
  // memory port
  output logic                        O_MEMORY_OUTPUT_CLOCK,
  output logic                        O_MEMORY_BUS_OE_N,
  output logic [CE_W-1:0]             O_CHIP_EN_N,
  output logic [BE_W-1:0]             O_BYTE_LANE_ENABLES_N,
  output logic [ADDR_HI:ADDR_LO]      O_MEMORY_ADDRESS_BUS,
  output logic [DATA_W-1:0]           O_MEMORY_DATA_BUS,
  output logic                        O_MEMORY_DATA_BUS_OE_N,
  input  wire logic [DATA_W-1:0]      I_MEMORY_DATA_BUS,
  output logic                        O_ASYNC_READ_STROBE_N,
  output logic                        O_ASYNC_OUTPUT_ENABLE_N,
  output logic                        O_ASYNC_WRITE_STROBE_N,
  input  wire logic                   I_ASYNC_READY_INPUT,
  output logic                        O_DRAM_ROW_STROBE_N,
  output logic                        O_DRAM_COLUMN_STROBE_N,
  output logic                        O_DRAM_WRITE_STROBE_N,
  output logic                        O_DRAM_A10_LINE
);

  // ************************************************************
  // declarations
  // ************************************************************
  ebhh_state_type            state_r;
  ebhh_kind_type             kind_r;
  logic [3:0]                cnt_r;
  logic [3:0]                burst_cnt_r;
  logic [1:0]                space_r;
  logic [ADDR_HI:ADDR_LO]    addr_r;
  logic [BE_W-1:0]           be_r;
  logic [DATA_W-1:0]         wdata_r;
  logic [DATA_W-1:0]         din_s1_r;
  logic [DATA_W-1:0]         din_s2_r;
  logic [1:0]                pin_sync;
  logic                      hold_req;
  logic                      ready_sync;
  logic                      hold_pend;
  logic                      burst_ok;
  logic                      accept;
  logic                      acc_end;
  logic                      write_run_r;
  logic                      bus_hiz_r;
  logic                      data_oe_n_r;
  logic [2:0]                strobe_nxt;
  logic [2:0]                strobe_r;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  ebhh_sync2 #(
    .W       (2),
    .RST_VAL (SYNC_RST_VAL)
  ) u_sync (
    .i_clk   (I_CLK_SYS),
    .i_rst   (I_SYS_RST),
    .i_async ({I_HOLD_REQ_N, I_ASYNC_READY_INPUT}),
    .o_sync  (pin_sync)
  );

  assign hold_req   = ~pin_sync[1];
  assign ready_sync = pin_sync[0];

  // ************************************************************
  // acceptance and hold arbitration
  // ************************************************************
  assign hold_pend = hold_req && !I_GRANT_REFUSE_BIT;
  assign burst_ok  = I_BURST_LIMIT_SETTING && is_dram_rw(I_ACC_KIND) &&
                     (burst_cnt_r != CNT_RST) && (burst_cnt_r < BURST_LIMIT_RUN);
  assign O_ACC_READY = (state_r == ST_IDLE) && (!hold_pend || burst_ok);
  assign accept      = I_ACC_VALID && O_ACC_READY;
  assign acc_end     = ((state_r == ST_SCMD) && (cnt_r == 4'(SYNC_CMD_CYC - 1))) ||
                       ((state_r == ST_ASTB) && (cnt_r == 4'(ASYNC_STROBE_CYC - 1)) && ready_sync);

  // ************************************************************
  // main state machine
  // ************************************************************
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      state_r <= ST_IDLE;
      cnt_r   <= CNT_RST;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          cnt_r <= CNT_RST;
          if (accept) begin
            if (is_sync_wr(I_ACC_KIND) && !write_run_r) begin
              state_r <= ST_LEAD;
            end else if (is_async(I_ACC_KIND)) begin
              state_r <= ST_ASTB;
            end else begin
              state_r <= ST_SCMD;
            end
          end else if (hold_pend) begin
            state_r <= ST_HIZW;
          end
        end
        ST_LEAD: begin
          if (cnt_r == 4'(LEAD_CYC - 1)) begin
            state_r <= ST_SCMD;
            cnt_r   <= CNT_RST;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ST_SCMD: begin
          if (acc_end) begin
            state_r <= ST_IDLE;
            cnt_r   <= CNT_RST;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ST_ASTB: begin
          if (cnt_r != 4'(ASYNC_STROBE_CYC - 1)) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (ready_sync) begin
            state_r <= ST_IDLE;
            cnt_r   <= CNT_RST;
          end
        end
        ST_HIZW: begin
          if (!hold_pend) begin
            state_r <= ST_IDLE;
            cnt_r   <= CNT_RST;
          end else if (cnt_r == 4'(HIZ_WAIT_CYC - 1)) begin
            state_r <= ST_HOLD;
            cnt_r   <= CNT_RST;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ST_HOLD: begin
          if (!hold_req) begin
            state_r <= ST_RELW;
          end
        end
        ST_RELW: begin
          if (cnt_r == 4'(DRIVE_WAIT_CYC - 1)) begin
            state_r <= ST_IDLE;
            cnt_r   <= CNT_RST;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          cnt_r   <= CNT_RST;
        end
      endcase
    end
  end

  // ************************************************************
  // access capture, run tracking
  // ************************************************************
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      kind_r  <= KIND_ASYNC_RD;
      space_r <= 2'h0;
      addr_r  <= '0;
      be_r    <= '0;
      wdata_r <= '0;
    end else if (accept) begin
      kind_r  <= I_ACC_KIND;
      space_r <= I_ACC_SPACE;
      addr_r  <= I_ACC_ADDR;
      be_r    <= I_ACC_BE;
      wdata_r <= I_ACC_WDATA;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      burst_cnt_r <= CNT_RST;
    end else if (accept) begin
      burst_cnt_r <= !is_dram_rw(I_ACC_KIND) ? CNT_RST :
                     (burst_cnt_r == BURST_LIMIT_RUN) ? burst_cnt_r : burst_cnt_r + 4'h1;
    end else if (state_r == ST_IDLE) begin
      burst_cnt_r <= CNT_RST;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      write_run_r <= 1'b0;
    end else if (acc_end && is_sync_wr(kind_r)) begin
      write_run_r <= 1'b1;
    end else if ((state_r == ST_IDLE) && !(accept && is_sync_wr(I_ACC_KIND))) begin
      write_run_r <= 1'b0;
    end
  end

  // ************************************************************
  // bus release and acknowledge
  // ************************************************************
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      bus_hiz_r <= 1'b0;
    end else if ((state_r == ST_HIZW) && hold_pend && (cnt_r == 4'(HIZ_WAIT_CYC - 1))) begin
      bus_hiz_r <= 1'b1;
    end else if ((state_r == ST_RELW) && (cnt_r == 4'(DRIVE_WAIT_CYC - 1))) begin
      bus_hiz_r <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      O_BUS_GRANT_ACK_N <= 1'b1;
    end else begin
      O_BUS_GRANT_ACK_N <= ~bus_hiz_r;
    end
  end

  // released group: pins behind the memory bus and data bus output enables
  assign O_MEMORY_BUS_OE_N      = bus_hiz_r;
  assign O_MEMORY_DATA_BUS_OE_N = data_oe_n_r | bus_hiz_r;

  // ************************************************************
  // shared strobe roles
  // ************************************************************
  always_comb begin
    strobe_nxt = STROBE_IDLE;
    if (state_r == ST_SCMD) begin
      unique case (kind_r)
        KIND_DRAM_RD:  strobe_nxt = CMD_READ;
        KIND_DRAM_WR:  strobe_nxt = CMD_WRT;
        KIND_DRAM_ACT: strobe_nxt = CMD_BANK_ACTIVATE_CMD;
        KIND_DRAM_PRE: strobe_nxt = CMD_PRE;
        KIND_DRAM_REF: strobe_nxt = CMD_REFRESH_CMD;
        KIND_DRAM_MOD: strobe_nxt = CMD_MODE;
        // row pin as output enable, column as address strobe
        KIND_SBS_RD:   strobe_nxt = 3'h1;
        KIND_SBS_WR:   strobe_nxt = 3'h4;
        default:       strobe_nxt = STROBE_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      strobe_r <= STROBE_IDLE;
    end else begin
      strobe_r <= strobe_nxt;
    end
  end

  assign O_DRAM_ROW_STROBE_N    = strobe_r[2];
  assign O_DRAM_COLUMN_STROBE_N = strobe_r[1];
  assign O_DRAM_WRITE_STROBE_N  = strobe_r[0];

  // ************************************************************
  // address, selects, data and async strobes
  // ************************************************************
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      O_CHIP_EN_N             <= '1;
      O_BYTE_LANE_ENABLES_N   <= '1;
      O_MEMORY_ADDRESS_BUS    <= '0;
      O_MEMORY_DATA_BUS       <= '0;
      data_oe_n_r             <= 1'b1;
      O_DRAM_A10_LINE         <= 1'b0;
      O_ASYNC_READ_STROBE_N   <= 1'b1;
      O_ASYNC_OUTPUT_ENABLE_N <= 1'b1;
      O_ASYNC_WRITE_STROBE_N  <= 1'b1;
    end else begin
      O_CHIP_EN_N             <= '1;
      O_BYTE_LANE_ENABLES_N   <= '1;
      data_oe_n_r             <= 1'b1;
      O_DRAM_A10_LINE         <= 1'b0;
      O_ASYNC_READ_STROBE_N   <= 1'b1;
      O_ASYNC_OUTPUT_ENABLE_N <= 1'b1;
      O_ASYNC_WRITE_STROBE_N  <= 1'b1;
      O_MEMORY_ADDRESS_BUS    <= addr_r;
      O_MEMORY_DATA_BUS       <= wdata_r;
      if (state_r == ST_LEAD) begin
        data_oe_n_r <= 1'b0;
      end
      if ((state_r == ST_SCMD) || (state_r == ST_ASTB)) begin
        O_CHIP_EN_N[space_r]  <= 1'b0;
        O_BYTE_LANE_ENABLES_N <= ~be_r;
        data_oe_n_r           <= is_read(kind_r) || !(is_sync_wr(kind_r) || is_async(kind_r));
      end
      if (state_r == ST_SCMD) begin
        O_DRAM_A10_LINE <= (kind_r == KIND_DRAM_PRE) ||
                           (((kind_r == KIND_DRAM_ACT) || (kind_r == KIND_DRAM_MOD)) &&
                            addr_r[A10_ADDR_BIT]);
      end
      if (state_r == ST_ASTB) begin
        O_ASYNC_READ_STROBE_N   <= !is_read(kind_r);
        O_ASYNC_OUTPUT_ENABLE_N <= !is_read(kind_r);
        O_ASYNC_WRITE_STROBE_N  <= is_read(kind_r);
      end
    end
  end

  // ************************************************************
  // read return and memory clock
  // ************************************************************
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      din_s1_r   <= '0;
      din_s2_r   <= '0;
      O_RD_DATA  <= '0;
      O_RD_VALID <= 1'b0;
      O_ACC_DONE <= 1'b0;
    end else begin
      din_s1_r   <= I_MEMORY_DATA_BUS;
      din_s2_r   <= din_s1_r;
      O_ACC_DONE <= acc_end;
      O_RD_VALID <= acc_end && is_read(kind_r);
      if (acc_end && is_read(kind_r)) begin
        O_RD_DATA <= din_s2_r;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      O_MEMORY_OUTPUT_CLOCK <= 1'b0;
    end else begin
      O_MEMORY_OUTPUT_CLOCK <= ~O_MEMORY_OUTPUT_CLOCK;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);

  sequence s_lead_run;
    (state_r == ST_LEAD) [*2] ##1 (state_r == ST_SCMD);
  endsequence

  chk_hiz_min_delay: assert property ($rose(bus_hiz_r) |-> $past(hold_req, 2) && $past(hold_req, 1))
    else $error("bus floated too early after hold request");
  chk_ack_after_hiz: assert property ($rose(bus_hiz_r) |-> ##[1:2] !O_BUS_GRANT_ACK_N)
    else $error("acknowledge late after bus float");
  chk_drive_resume: assert property ($fell(bus_hiz_r) |-> !$past(hold_req, 1) && !$past(hold_req, 2))
    else $error("bus driven too soon after release");
  chk_ack_release: assert property ($fell(bus_hiz_r) |-> ##[1:2] O_BUS_GRANT_ACK_N)
    else $error("acknowledge late after bus drive");
  chk_refuse_no_grant: assert property (I_GRANT_REFUSE_BIT && (state_r == ST_IDLE) |=> state_r != ST_HIZW)
    else $error("hold started while refused");
  chk_hold_idle_bus: assert property ((state_r == ST_HOLD) |-> bus_hiz_r ##1 !O_ACC_READY)
    else $error("bus active during hold");
  chk_pending_done: assert property ($fell(O_BUS_GRANT_ACK_N) |-> $past(state_r, 1) == ST_HOLD)
    else $error("acknowledge while transfer pending");
  chk_dram_read_cmd: assert property ((state_r == ST_SCMD) && (kind_r == KIND_DRAM_RD) |=> strobe_r == CMD_READ)
    else $error("dram read strobes wrong");
  chk_sbs_write: assert property ((state_r == ST_SCMD) && (kind_r == KIND_SBS_WR) |=> strobe_r == 3'h4)
    else $error("burst sram write strobes wrong");
  chk_data_lead: assert property ($rose(state_r == ST_LEAD) |-> s_lead_run ##1 !data_oe_n_r)
    else $error("early write data not launched");

endmodule

// ==== ebhh_pkg.sv ====
// shared constants, types and decode functions for the hold handoff block
// assumes a single 100 MHz system clock that is also the cpu clock period
package ebhh_pkg;

  // ************************************************************
  // clock and time
  // ************************************************************
  localparam int CLK_PERIOD_NS  = 10;
  localparam int CPU_PERIOD_NS  = 10;
  localparam int SYNC_DEPTH     = 2;
  // times in cpu clock periods
  localparam int HIZ_MIN_P      = 4;
  localparam int ACK_MAX_P      = 2;
  localparam int RESUME_MIN_P   = 3;
  localparam int RESUME_MAX_P   = 7;
  // least times round up, longest round down
  localparam int HIZ_MIN_CYC    = (HIZ_MIN_P * CPU_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACK_MAX_CYC    = (ACK_MAX_P * CPU_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int RESUME_MIN_CYC = (RESUME_MIN_P * CPU_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESUME_MAX_CYC = (RESUME_MAX_P * CPU_PERIOD_NS) / CLK_PERIOD_NS;
  // waits left after the synchroniser latency
  localparam int HIZ_WAIT_CYC   = HIZ_MIN_CYC - SYNC_DEPTH;
  localparam int DRIVE_WAIT_CYC = RESUME_MIN_CYC - SYNC_DEPTH;

  // ************************************************************
  // access timing
  // ************************************************************
  localparam int MEM_CLK_DIV      = 2;
  localparam int LEAD_CYC         = MEM_CLK_DIV;
  localparam int SYNC_CMD_CYC     = MEM_CLK_DIV;
  localparam int ASYNC_STROBE_CYC = 4;
  localparam logic [3:0] BURST_LIMIT_RUN = 4'h8;
  localparam logic [3:0] CNT_RST  = 4'h0;

  // ************************************************************
  // widths, fields and reset values
  // ************************************************************
  localparam int DATA_W     = 32;
  localparam int ADDR_HI    = 21;
  localparam int ADDR_LO    = 2;
  localparam int CE_W       = 4;
  localparam int BE_W       = 4;
  localparam int A10_ADDR_BIT = 12;
  localparam logic [1:0] SYNC_RST_VAL = 2'h2;
  localparam logic [2:0] STROBE_IDLE  = 3'h7;

  // dram commands as {row, column, write} strobes, active low
  localparam logic [2:0] CMD_BANK_ACTIVATE_CMD = 3'h3;
  localparam logic [2:0] CMD_PRE  = 3'h2;
  localparam logic [2:0] CMD_REFRESH_CMD = 3'h1;
  localparam logic [2:0] CMD_MODE = 3'h0;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRT  = 3'h4;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [3:0] {
    KIND_ASYNC_RD = 4'h0,
    KIND_ASYNC_WR = 4'h1,
    KIND_DRAM_RD  = 4'h2,
    KIND_DRAM_WR  = 4'h3,
    KIND_DRAM_ACT = 4'h4,
    KIND_DRAM_PRE = 4'h5,
    KIND_DRAM_REF = 4'h6,
    KIND_DRAM_MOD = 4'h7,
    KIND_SBS_RD   = 4'h8,
    KIND_SBS_WR   = 4'h9
  } ebhh_kind_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LEAD = 3'h1,
    ST_SCMD = 3'h2,
    ST_ASTB = 3'h3,
    ST_HIZW = 3'h4,
    ST_HOLD = 3'h5,
    ST_RELW = 3'h6
  } ebhh_state_type;

  // ************************************************************
  // decode functions
  // ************************************************************
  function automatic logic is_dram_rw(input ebhh_kind_type k);
    return (k == KIND_DRAM_RD) || (k == KIND_DRAM_WR);
  endfunction

  function automatic logic is_sync_wr(input ebhh_kind_type k);
    return (k == KIND_DRAM_WR) || (k == KIND_SBS_WR);
  endfunction

  function automatic logic is_async(input ebhh_kind_type k);
    return (k == KIND_ASYNC_RD) || (k == KIND_ASYNC_WR);
  endfunction

  function automatic logic is_read(input ebhh_kind_type k);
    return (k == KIND_ASYNC_RD) || (k == KIND_DRAM_RD) || (k == KIND_SBS_RD);
  endfunction

endpackage

// ==== ebhh_sync2.sv ====
// two flip-flop synchroniser for levels arriving from pins
// assumes the destination clock is the system clock
`timescale 1ns/1ps
module ebhh_sync2 #(
  parameter int         W       = 2,
  parameter logic [1:0] RST_VAL = 2'h0
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_r <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule

// ==== ebhh_req_model.sv ====
// outside bus master that asks for the memory bus with an active low hold request
// assumes the bench raises i_go to ask and drops it to give the bus back
`timescale 1ns/1ps
module ebhh_req_model (
  // control
  input  wire logic i_clk,
  input  wire logic i_go,
  // hold handshake
  input  wire logic i_ack_n,
  output logic      o_hold_req_n
);
  // ********************
  // request line
  // ********************
  logic seen_r;
  initial begin
    o_hold_req_n = 1'b1;
    seen_r       = 1'b0;
  end
  // release once acknowledge was seen low a full period earlier, or at once while acknowledge is high
  always @(negedge i_clk) begin
    seen_r <= !i_ack_n;
    if (i_go) begin
      o_hold_req_n <= 1'b0;
    end else if (i_ack_n || seen_r) begin
      o_hold_req_n <= 1'b1;
    end
  end
endmodule

// ==== external_bus_hold_handoff_test.sv ====
// self-checking bench for the bus hold handoff block
// assumes the package, the design and the requester model are compiled first
`timescale 1ns/1ps
module external_bus_hold_handoff_test;
  import ebhh_pkg::*;
  // ********************
  // signals
  // ********************
  logic                   clk         = 1'b0;
  logic                   rst         = 1'b1;
  logic                   valid       = 1'b0;
  logic                   refuse      = 1'b0;
  logic                   rdy         = 1'b1;
  logic                   go          = 1'b0;
  ebhh_kind_type          kind        = KIND_DRAM_RD;
  logic [ADDR_HI:ADDR_LO] addr        = '0;
  logic [DATA_W-1:0]      wdata       = 32'hc3c3_3c3c;
  logic [DATA_W-1:0]      mdata       = 32'h5a5a_0f0f;
  logic                   ready, done, rd_valid, hold_n, ack_n, boe_n, doe_n, ras, cas, we, a10;
  logic [CE_W-1:0]        ce_n;
  logic [DATA_W-1:0]      rd_data;
  logic                   burst       = 1'b0;
  logic                   are_n, aoe_n, awe_n;
  logic [DATA_W-1:0]      mbus;
  int                     fail_count  = 0;
  int                     checks_done = 0;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  ebhh_top i_dut (
    .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_ACC_VALID(valid), .O_ACC_READY(ready), .I_ACC_KIND(kind),
    .I_ACC_SPACE(2'h0), .I_ACC_ADDR(addr), .I_ACC_BE(4'hf), .I_ACC_WDATA(wdata), .O_ACC_DONE(done),
    .O_RD_VALID(rd_valid), .O_RD_DATA(rd_data), .I_GRANT_REFUSE_BIT(refuse), .I_BURST_LIMIT_SETTING(burst),
    .I_HOLD_REQ_N(hold_n), .O_BUS_GRANT_ACK_N(ack_n), .O_MEMORY_OUTPUT_CLOCK(), .O_MEMORY_BUS_OE_N(boe_n),
    .O_CHIP_EN_N(ce_n), .O_BYTE_LANE_ENABLES_N(), .O_MEMORY_ADDRESS_BUS(), .O_MEMORY_DATA_BUS(mbus),
    .O_MEMORY_DATA_BUS_OE_N(doe_n), .I_MEMORY_DATA_BUS(mdata), .O_ASYNC_READ_STROBE_N(are_n),
    .O_ASYNC_OUTPUT_ENABLE_N(aoe_n), .O_ASYNC_WRITE_STROBE_N(awe_n), .I_ASYNC_READY_INPUT(rdy),
    .O_DRAM_ROW_STROBE_N(ras), .O_DRAM_COLUMN_STROBE_N(cas), .O_DRAM_WRITE_STROBE_N(we), .O_DRAM_A10_LINE(a10));

  ebhh_req_model i_req (.i_clk(clk), .i_go(go), .i_ack_n(ack_n), .o_hold_req_n(hold_n));

  // ********************
  // helpers
  // ********************
  task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick;
    @(negedge clk);
    #1;
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0: return boe_n;
      1: return ack_n;
      default: return done;
    endcase
  endfunction
  // counts ticks until the chosen output reaches val
  task automatic wait_sig(input int sel, input logic val, output int n);
    n = 0;
    while (pick(sel) !== val && n < 30) begin
      tick;
      n++;
    end
    if (n == 30) begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  // one access; reports strobes at the command and data lead before it
  task automatic do_acc(input ebhh_kind_type k, output logic [3:0] strb, output int lead);
    int   n;
    int   t_c;
    int   t_d;
    logic take;
    kind  = k;
    valid = 1'b1;
    t_c   = -1;
    t_d   = -1;
    strb  = 4'hf;
    for (n = 0; n < 40; n++) begin
      take = valid && (ready === 1'b1);
      tick;
      if (take) valid = 1'b0;
      if (t_d < 0 && doe_n === 1'b0) t_d = n;
      if (t_c < 0 && {ras, cas, we} !== 3'h7) begin
        t_c  = n;
        strb = {ras, cas, we, a10};
      end
      if (done === 1'b1) break;
    end
    if (n == 40) begin
      fail_count++;
      tally_and_finish();
    end
    lead = t_c - t_d;
  endtask
  // {expected strobes, mask} as row, column, write pins
  function automatic logic [5:0] cmd_exp(input ebhh_kind_type k);
    case (k)
      KIND_DRAM_RD:  return {3'h5, 3'h7};
      KIND_DRAM_WR:  return {3'h4, 3'h7};
      KIND_DRAM_ACT: return {3'h3, 3'h7};
      KIND_DRAM_PRE: return {3'h2, 3'h7};
      KIND_DRAM_REF: return {3'h1, 3'h7};
      KIND_DRAM_MOD: return {3'h0, 3'h7};
      KIND_SBS_RD:   return {3'h1, 3'h3};
      default:       return {3'h0, 3'h3};
    endcase
  endfunction

  // ********************
  // scenarios
  // ********************
  task automatic sc_hold;
    int n;
    int m;
    go = 1'b1;
    tick;
    wait_sig(0, 1'b1, n);
    check_eq(n, HIZ_MIN_CYC + 1);
    check_eq(doe_n, 1'b1);
    wait_sig(1, 1'b0, m);
    check_eq(m <= ACK_MAX_CYC, 1'b1);
    m = 0;
    repeat (6) begin
      tick;
      m += (ready !== 1'b0) + (boe_n !== 1'b1) + (doe_n !== 1'b1);
    end
    check_eq(m, 0);
    go = 1'b0;
    tick;
    check_eq(hold_n, 1'b1);
    wait_sig(0, 1'b0, n);
    check_eq(n >= RESUME_MIN_CYC + 1 && n <= RESUME_MAX_CYC, 1'b1);
    wait_sig(1, 1'b1, m);
    check_eq(m <= ACK_MAX_CYC, 1'b1);
  endtask
  // reads come before writes so each write opens a run
  task automatic sc_cmds;
    logic [3:0] s;
    logic [5:0] e;
    int         ld;
    for (int k = 2; k < 10; k++) begin
      do_acc(ebhh_kind_type'(k), s, ld);
      e = cmd_exp(ebhh_kind_type'(k));
      check_eq(s[3:1] & e[2:0], e[5:3]);
      if (k == 5) check_eq(s[0], 1'b1);
      if (k == 3 || k == 9) check_eq(ld, MEM_CLK_DIV);
      if (k == 3) check_eq(mbus, wdata);
      if (k == 2 || k == 8) check_eq(rd_valid, 1'b1);
      if (k == 2 || k == 8) check_eq(rd_data, mdata);
    end
  endtask
  task automatic sc_refuse;
    logic [3:0] s;
    int         ld;
    int         m;
    refuse = 1'b1;
    go     = 1'b1;
    m      = 0;
    repeat (20) begin
      tick;
      m += (ack_n !== 1'b1);
    end
    do_acc(KIND_DRAM_RD, s, ld);
    check_eq(m + (ack_n !== 1'b1), 0);
    go = 1'b0;
    repeat (4) tick;
    refuse = 1'b0;
    repeat (8) tick;
  endtask
  // hold asked while a ready-stretched access is open
  task automatic sc_pending;
    int n;
    int m;
    rdy   = 1'b0;
    kind  = KIND_ASYNC_RD;
    valid = 1'b1;
    go    = 1'b1;
    check_eq(ready, 1'b1);
    tick;
    valid = 1'b0;
    m     = 0;
    repeat (12) begin
      tick;
      m += (ack_n !== 1'b1) + (done !== 1'b0);
    end
    check_eq(m, 0);
    check_eq({ce_n, are_n, aoe_n, awe_n}, 7'h71);
    rdy = 1'b1;
    wait_sig(2, 1'b1, n);
    check_eq(ack_n, 1'b1);
    check_eq(rd_data, mdata);
    wait_sig(1, 1'b0, n);
    go = 1'b0;
    wait_sig(1, 1'b1, n);
  endtask
  // hold asked with burst limit on: eight back-to-back dram reads still go first
  task automatic sc_burst;
    logic [3:0] s;
    int         ld;
    int         n;
    burst = 1'b1;
    go    = 1'b1;
    repeat (8) begin
      do_acc(KIND_DRAM_RD, s, ld);
      check_eq(s[3:1], CMD_READ);
    end
    check_eq(ready, 1'b0);
    wait_sig(1, 1'b0, n);
    check_eq(boe_n, 1'b1);
    go    = 1'b0;
    burst = 1'b0;
    wait_sig(1, 1'b1, n);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    tick;
    rst = 1'b0;
    tick;
    check_eq({ack_n, boe_n, doe_n, ready}, 4'hb);
    sc_hold();
    sc_cmds();
    sc_refuse();
    sc_pending();
    sc_burst();
    tally_and_finish();
  end
endmodule
